// file: hw/bcc_pkg.sv
// package: register map, field layouts and calendar types for the bcd calendar clock
package bcc_pkg;

	// ************************************************************
	// register offsets (byte addresses, one word each)
	// ************************************************************
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_VAL_HIGH = 8'h04;
	localparam logic [7:0] OFS_VAL_LOW = 8'h08;
	localparam logic [7:0] OFS_UNLOCK_SEQ = 8'h0C;
	localparam logic [7:0] OFS_ALARM_HOUR = 8'h10;
	localparam logic [7:0] OFS_ALARM_MINUTE = 8'h14;
	localparam logic [7:0] OFS_ALARM_SECOND = 8'h18;
	localparam logic [7:0] OFS_PAD_CFG = 8'h1C;
	localparam logic [7:0] OFS_HALF_SEC = 8'h20;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CFG_RUN_BIT = 7;
	localparam int CFG_UNLOCK_BIT = 5;
	localparam int CFG_SYNC_BIT = 4;
	localparam int PAD_SEL_LSB = 1;

	// ************************************************************
	// field masks and reset values
	// ************************************************************
	localparam logic [7:0] MASK_SEC = 8'h7F;
	localparam logic [7:0] MASK_MIN = 8'h7F;
	localparam logic [7:0] MASK_HOUR = 8'h3F;
	localparam logic [7:0] MASK_WDAY = 8'h07;
	localparam logic [7:0] MASK_DAY = 8'h3F;
	localparam logic [7:0] MASK_MONTH = 8'h1F;
	localparam logic [7:0] MASK_YEAR = 8'hFF;
	localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
	localparam logic [7:0] RST_BCD_ZERO = 8'h00;
	localparam logic [7:0] RST_BCD_ONE = 8'h01;

	// ************************************************************
	// pin output select codes and timing counts
	// ************************************************************
	localparam logic [1:0] PIN_SEL_OFF = 2'h0;
	localparam logic [1:0] PIN_SEL_SECONDS = 2'h1;
	localparam logic [1:0] PIN_SEL_CLOCK = 2'h2;
	localparam int CRYSTAL_HZ = 32768;
	localparam logic [13:0] HALF_SEC_LAST = 14'(CRYSTAL_HZ / 2 - 1);
	localparam logic [13:0] SYNC_WINDOW_START = 14'(CRYSTAL_HZ / 2 - 32);

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		UNL_IDLE = 2'b00,
		UNL_GOT_FIRST = 2'b01,
		UNL_READY = 2'b10
	} bcc_unlock_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} bcc_apb_req_type;

	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} bcc_time_type;

endpackage

// file: hw/bcc_top.sv
// module: bcd calendar clock with apb register access
`timescale 1ns/1ps
module bcc_top (
	// clock, reset, clock enable
	input wire logic I_REF_CLK,
	input wire logic I_ARST_N,
	input wire logic I_CLK_EN,
	// apb slave
	input wire bcc_pkg::bcc_apb_req_type I_APB,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// counter clock sources and selection
	input wire logic I_SECONDARY_CRYSTAL_OSC_CLK,
	input wire logic I_LFINT_CLK,
	input wire logic I_CLOCK_SOURCE_SELECT,
	// calendar output pin
	output logic O_CAL_PIN
);
	import bcc_pkg::*;

	// ************************************************************
	// functions
	// ************************************************************
	// bcd increment: returns {wrapped, next}
	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
		input logic [7:0] first);
		logic [8:0] r;
		r = {1'b0, v + 8'h01};
		if (v == last) begin
			r = {1'b1, first};
		end else if (v[3:0] == 4'h9) begin
			r = {1'b0, v[7:4] + 4'h1, 4'h0};
		end
		return r;
	endfunction

	// last day of a bcd month
	function automatic logic [7:0] month_last(input logic [7:0] m, input logic leap);
		logic [7:0] r;
		r = 8'h31;
		if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
			r = 8'h30;
		end else if (m == 8'h02) begin
			r = leap ? 8'h29 : 8'h28;
		end
		return r;
	endfunction

	// ************************************************************
	// apb decode
	// ************************************************************
	wire logic apb_setup = I_APB.psel & ~I_APB.penable;
	wire logic apb_done = I_APB.psel & I_APB.penable;
	wire logic apb_wr = apb_done & I_APB.pwrite & I_CLK_EN;
	wire logic apb_rd = apb_done & ~I_APB.pwrite & I_CLK_EN;
	wire logic [7:0] wdata = I_APB.pwdata[7:0];
	wire logic hit_cfg = I_APB.paddr == OFS_CFG;
	wire logic hit_valh = I_APB.paddr == OFS_VAL_HIGH;
	wire logic hit_vall = I_APB.paddr == OFS_VAL_LOW;
	wire logic hit_unl = I_APB.paddr == OFS_UNLOCK_SEQ;
	wire logic hit_ahr = I_APB.paddr == OFS_ALARM_HOUR;
	wire logic hit_amin = I_APB.paddr == OFS_ALARM_MINUTE;
	wire logic hit_asec = I_APB.paddr == OFS_ALARM_SECOND;
	wire logic hit_pad = I_APB.paddr == OFS_PAD_CFG;
	wire logic hit_half = I_APB.paddr == OFS_HALF_SEC;
	wire logic mapped = hit_cfg | hit_valh | hit_vall | hit_unl | hit_ahr | hit_amin | hit_asec
		| hit_pad | hit_half;

	// zero wait states; unmapped addresses answer with an error
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = apb_done & ~mapped;

	// ************************************************************
	// state
	// ************************************************************
	logic run_enable;
	logic unlock_flag;
	logic [1:0] value_pointer;
	logic [1:0] pin_output_select;
	logic [7:0] alarm_hour_value;
	logic [7:0] alarm_minute_value;
	logic [7:0] alarm_second_value;
	bcc_unlock_type unl_state;
	bcc_time_type tm;
	logic [13:0] prescaler;
	logic half_sec;
	logic [2:0] src_sync;
	logic [2:0] clk_sync;
	logic clk_stable;
	logic clk_level_q;

	// ************************************************************
	// counter clock selection and sampling
	// ************************************************************
	// source select is a static strap, sampled like any pin
	wire logic src_internal = src_sync[2] & src_sync[1];
	wire logic src_raw = src_internal ? I_LFINT_CLK : I_SECONDARY_CRYSTAL_OSC_CLK;

	// three-stage sampling; a level counts once stages two and three agree
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			src_sync <= 3'h0;
			clk_sync <= 3'h0;
			clk_stable <= 1'b0;
		end else if (I_CLK_EN) begin
			src_sync <= {src_sync[1:0], I_CLOCK_SOURCE_SELECT};
			clk_sync <= {clk_sync[1:0], src_raw};
			if (clk_sync[2] == clk_sync[1]) begin
				clk_stable <= clk_sync[2];
			end
		end
	end

	wire logic clk_rise = clk_sync[2] & clk_sync[1] & ~clk_stable;

	// ************************************************************
	// prescaler and seconds tick
	// ************************************************************
	wire logic pre_last = prescaler == HALF_SEC_LAST;
	wire logic sec_tick = run_enable & clk_rise & pre_last & half_sec;
	wire logic sync_window = run_enable & half_sec & (prescaler >= SYNC_WINDOW_START);

	// ************************************************************
	// value window decode
	// ************************************************************
	wire logic valh_wr = apb_wr & hit_valh & unlock_flag;
	wire logic vall_wr = apb_wr & hit_vall & unlock_flag;
	wire logic ptr_minute_second_pair = value_pointer == 2'h0;
	wire logic ptr_hour = value_pointer == 2'h1;
	wire logic ptr_date = value_pointer == 2'h2;
	wire logic ptr_year = value_pointer == 2'h3;
	// a write to either half of the minute/second pair realigns the sub-second phase
	wire logic minute_second_pair_wr = (valh_wr | vall_wr) & ptr_minute_second_pair;
	wire logic valh_access = (apb_wr | apb_rd) & hit_valh;

	// window read mux; the high half at pointer 3 has no register
	wire logic [7:0] valh_rd = ptr_minute_second_pair ? tm.minute : ptr_hour ? tm.wday : ptr_date ? tm.month : 8'h00;
	wire logic [7:0] vall_rd = ptr_minute_second_pair ? tm.second : ptr_hour ? tm.hour : ptr_date ? tm.day : tm.year;

	// ************************************************************
	// calendar carry chain
	// ************************************************************
	// leap when the bcd year is divisible by four
	wire logic leap = tm.year[4] ? (tm.year[3:0] == 4'h2 || tm.year[3:0] == 4'h6) :
		(tm.year[3:0] == 4'h0 || tm.year[3:0] == 4'h4 || tm.year[3:0] == 4'h8);
	wire logic [8:0] sec_inc = bcd_inc(tm.second, 8'h59, RST_BCD_ZERO);
	wire logic [8:0] min_inc = bcd_inc(tm.minute, 8'h59, RST_BCD_ZERO);
	wire logic [8:0] hour_inc = bcd_inc(tm.hour, 8'h23, RST_BCD_ZERO);
	wire logic [8:0] wday_inc = bcd_inc(tm.wday, 8'h06, RST_BCD_ZERO);
	wire logic [8:0] day_inc = bcd_inc(tm.day, month_last(tm.month, leap), RST_BCD_ONE);
	wire logic [8:0] month_inc = bcd_inc(tm.month, 8'h12, RST_BCD_ONE);
	wire logic [8:0] year_inc = bcd_inc(tm.year, 8'h99, RST_BCD_ZERO);
	wire logic min_carry = sec_tick & sec_inc[8];
	wire logic hour_carry = min_carry & min_inc[8];
	wire logic day_carry = hour_carry & hour_inc[8];
	wire logic month_carry = day_carry & day_inc[8];
	wire logic year_carry = month_carry & month_inc[8];

	bcc_time_type next_tm;

	// counting runs on; a field written this cycle takes the written value
	always_comb begin
		next_tm = tm;
		if (sec_tick) begin
			next_tm.second = sec_inc[7:0];
		end
		if (min_carry) begin
			next_tm.minute = min_inc[7:0];
		end
		if (hour_carry) begin
			next_tm.hour = hour_inc[7:0];
		end
		if (day_carry) begin
			next_tm.day = day_inc[7:0];
			next_tm.wday = wday_inc[7:0];
		end
		if (month_carry) begin
			next_tm.month = month_inc[7:0];
		end
		if (year_carry) begin
			next_tm.year = year_inc[7:0];
		end
		if (valh_wr) begin
			if (ptr_minute_second_pair) begin
				next_tm.minute = wdata & MASK_MIN;
			end else if (ptr_hour) begin
				next_tm.wday = wdata & MASK_WDAY;
			end else if (ptr_date) begin
				next_tm.month = wdata & MASK_MONTH;
			end
		end
		if (vall_wr) begin
			if (ptr_minute_second_pair) begin
				next_tm.second = wdata & MASK_SEC;
			end else if (ptr_hour) begin
				next_tm.hour = wdata & MASK_HOUR;
			end else if (ptr_date) begin
				next_tm.day = wdata & MASK_DAY;
			end else if (ptr_year) begin
				next_tm.year = wdata & MASK_YEAR;
			end
		end
	end

	// time registers and prescalers
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tm <= '{year: RST_BCD_ZERO, month: RST_BCD_ONE, day: RST_BCD_ONE, wday: RST_BCD_ZERO,
				hour: RST_BCD_ZERO, minute: RST_BCD_ZERO, second: RST_BCD_ZERO};
			prescaler <= 14'h0000;
			half_sec <= 1'b0;
		end else if (I_CLK_EN) begin
			tm <= next_tm;
			if (minute_second_pair_wr) begin
				prescaler <= 14'h0000;
				half_sec <= 1'b0;
			end else if (run_enable && clk_rise) begin
				prescaler <= pre_last ? 14'h0000 : prescaler + 14'h0001;
				if (pre_last) begin
					half_sec <= ~half_sec;
				end
			end
		end
	end

	// ************************************************************
	// unlock sequence
	// ************************************************************
	// the keys must be back to back; any other access closes the window
	bcc_unlock_type next_unl;
	always_comb begin
		next_unl = unl_state;
		if (apb_wr || apb_rd) begin
			case (unl_state)
				UNL_IDLE: begin
					next_unl = (apb_wr && hit_unl && wdata == UNLOCK_KEY_FIRST) ? UNL_GOT_FIRST : UNL_IDLE;
				end
				UNL_GOT_FIRST: begin
					next_unl = (apb_wr && hit_unl && wdata == UNLOCK_KEY_SECOND) ? UNL_READY : UNL_IDLE;
				end
				UNL_READY: begin
					next_unl = UNL_IDLE;
				end
				default: begin
					next_unl = UNL_IDLE;
				end
			endcase
		end
	end

	wire logic cfg_wr = apb_wr & hit_cfg;
	// setting the flag is only honoured on the access right after the keys
	wire logic unlock_set = cfg_wr & wdata[CFG_UNLOCK_BIT] & (unl_state == UNL_READY);

	// ************************************************************
	// configuration and alarm registers
	// ************************************************************
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			unl_state <= UNL_IDLE;
			unlock_flag <= 1'b0;
			run_enable <= 1'b0;
			value_pointer <= 2'h0;
			pin_output_select <= PIN_SEL_OFF;
			alarm_hour_value <= RST_BCD_ZERO;
			alarm_minute_value <= RST_BCD_ZERO;
			alarm_second_value <= RST_BCD_ZERO;
		end else if (I_CLK_EN) begin
			unl_state <= next_unl;
			if (cfg_wr) begin
				unlock_flag <= unlock_set | (unlock_flag & wdata[CFG_UNLOCK_BIT]);
				if (unlock_flag) begin
					run_enable <= wdata[CFG_RUN_BIT];
				end
				value_pointer <= wdata[1:0];
			end else if (valh_access && value_pointer != 2'h0) begin
				value_pointer <= value_pointer - 2'h1;
			end
			if (apb_wr && hit_pad) begin
				pin_output_select <= wdata[PAD_SEL_LSB+:2];
			end
			if (apb_wr && hit_ahr && unlock_flag) begin
				alarm_hour_value <= wdata & MASK_HOUR;
			end
			if (apb_wr && hit_amin) begin
				alarm_minute_value <= wdata & MASK_MIN;
			end
			if (apb_wr && hit_asec) begin
				alarm_second_value <= wdata & MASK_SEC;
			end
		end
	end

	// ************************************************************
	// read data and output pin
	// ************************************************************
	wire logic [7:0] cfg_rd = {run_enable, 1'b0, unlock_flag, sync_window, 2'h0, value_pointer};
	// reserved bits come back as zero: stored alarm and time values are masked, unused config, pad and half-second bits are tied to zero
	wire logic [7:0] rd_mux = hit_cfg ? cfg_rd : hit_valh ? valh_rd : hit_vall ? vall_rd :
		hit_ahr ? alarm_hour_value : hit_amin ? alarm_minute_value :
		hit_asec ? alarm_second_value : hit_pad ? {5'h00, pin_output_select, 1'b0} :
		hit_half ? {7'h00, half_sec} : 8'h00;

	// the internal clock reaches the pin only when it drives the counter
	wire logic pin_next = (pin_output_select == PIN_SEL_CLOCK) ? (src_internal & clk_stable) :
		(pin_output_select == PIN_SEL_SECONDS) ? half_sec : 1'b0;

	// read data sampled in the setup phase so it leaves a flip-flop
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_PRDATA <= 32'h00000000;
			O_CAL_PIN <= 1'b0;
		end else if (I_CLK_EN) begin
			if (apb_setup) begin
				O_PRDATA <= {24'h000000, rd_mux};
			end
			O_CAL_PIN <= pin_next;
		end
	end

endmodule

// file: sim/bcc_top_chk.sv
// checker: port-level assertions for the bcd calendar clock
`timescale 1ns/1ps
module bcc_top_chk (
	// clock, reset, enable
	input wire logic I_REF_CLK,
	input wire logic I_ARST_N,
	input wire logic I_CLK_EN,
	// apb
	input wire bcc_pkg::bcc_apb_req_type I_APB,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	// counter clocks and pin
	input wire logic I_SECONDARY_CRYSTAL_OSC_CLK,
	input wire logic I_LFINT_CLK,
	input wire logic I_CLOCK_SOURCE_SELECT,
	input wire logic O_CAL_PIN
);
	import bcc_pkg::*;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_ARST_N);

	// request phase decode
	wire acc = I_APB.psel && I_APB.penable;
	wire rd_setup = I_APB.psel && !I_APB.penable && !I_APB.pwrite && I_CLK_EN;
	wire mapped = (I_APB.paddr[1:0] == 2'h0) && (I_APB.paddr <= OFS_HALF_SEC);

	// read data loads at setup, so look in the access cycle
	property p_rd_zero(logic [7:0] a, logic [31:0] m);
		(rd_setup && I_APB.paddr == a) ##1 acc |-> (O_PRDATA & m) == 32'h0;
	endproperty

	// ****************
	// assertions
	// ****************
	chk_ready_high: assert property (O_PREADY) else $error("pready low");
	chk_err_decode: assert property (O_PSLVERR == (acc && !mapped)) else $error("pslverr decode wrong");
	chk_err_pulse: assert property (O_PSLVERR |=> !O_PSLVERR) else $error("pslverr held");
	chk_upper_zero: assert property (O_PRDATA[31:8] == 24'h0) else $error("prdata upper bits set");
	chk_data_stands: assert property (acc |=> $stable(O_PRDATA)) else $error("prdata moved after access");
	chk_hour_upper: assert property (p_rd_zero(OFS_ALARM_HOUR, 32'hFFFFFFC0))
		else $error("alarm hour upper bits set");
	chk_minute_upper: assert property (p_rd_zero(OFS_ALARM_MINUTE, 32'hFFFFFF80))
		else $error("alarm minute bit 7 set");
	chk_second_upper: assert property (p_rd_zero(OFS_ALARM_SECOND, 32'hFFFFFF80))
		else $error("alarm second bit 7 set");
	chk_unlock_reads: assert property (p_rd_zero(OFS_UNLOCK_SEQ, 32'hFFFFFFFF))
		else $error("key register not zero");
	chk_half_only: assert property (p_rd_zero(OFS_HALF_SEC, 32'hFFFFFFFE))
		else $error("half-second word has extra bits");

	// main scenarios seen
	cover property (acc && I_APB.pwrite);
	cover property (O_PSLVERR);
	cover property (rd_setup && I_APB.paddr == OFS_VAL_HIGH);
endmodule

bind bcc_top bcc_top_chk i_bcc_top_chk (.I_REF_CLK, .I_ARST_N, .I_CLK_EN, .I_APB, .O_PRDATA, .O_PREADY,
	.O_PSLVERR, .I_SECONDARY_CRYSTAL_OSC_CLK, .I_LFINT_CLK, .I_CLOCK_SOURCE_SELECT, .O_CAL_PIN);

// file: sim/bcc_top_tb.sv
// testbench: register-level checks of the bcd calendar clock
`timescale 1ns/1ps
module bcc_top_tb;
	import bcc_pkg::*;
	logic ref_clk = 1'h0;
	logic arst_n = 1'h0;
	logic clk_en = 1'h1;
	logic secondary_crystal_osc_clk = 1'h0;
	logic lfint_clk = 1'h0;
	bcc_apb_req_type apb_req = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cal_pin;
	int mismatches = 0;
	int n_tests = 0;
	int ones;
	logic [31:0] seed = 32'h809D598C;
	logic [31:0] q;
	logic [31:0] d;
	logic [7:0] a;
	logic e;
	// time fields walked from pointer 3 down to 0
	logic [7:0] win_addr [8] = '{OFS_VAL_LOW, OFS_VAL_HIGH, OFS_VAL_LOW, OFS_VAL_HIGH,
		OFS_VAL_LOW, OFS_VAL_HIGH, OFS_VAL_LOW, OFS_VAL_HIGH};
	logic [7:0] win_data [8] = '{8'h24, 8'h00, 8'h29, 8'h02, 8'h23, 8'h06, 8'h58, 8'h59};

	always #12.5 ref_clk = ~ref_clk;
	// counter clocks kept well below a quarter of the reference rate
	always begin
		repeat (4) @(posedge ref_clk);
		secondary_crystal_osc_clk <= ~secondary_crystal_osc_clk;
	end
	always begin
		repeat (3) @(posedge ref_clk);
		lfint_clk <= ~lfint_clk;
	end

	bcc_top i_bcc_top (
		.I_REF_CLK(ref_clk), .I_ARST_N(arst_n), .I_CLK_EN(clk_en), .I_APB(apb_req), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_SECONDARY_CRYSTAL_OSC_CLK(secondary_crystal_osc_clk), .I_LFINT_CLK(lfint_clk),
		.I_CLOCK_SOURCE_SELECT(1'h1), .O_CAL_PIN(cal_pin) // internal oscillator clocks the counter
	);

	// ****************
	// helpers
	// ****************
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [31:0] alarm_mask(input logic [7:0] r);
		return (r == OFS_ALARM_HOUR) ? 32'h3F : 32'h7F;
	endfunction

	// one apb transfer; request held until pready is seen
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge ref_clk);
		apb_req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: ad, pwdata: wd};
		@(posedge ref_clk);
		apb_req.penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		apb_req.psel <= 1'h0;
		apb_req.penable <= 1'h0;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_check(input logic [7:0] ad, input logic [31:0] exp);
		apb(1'h0, ad, 32'h0);
		check(q, exp);
	endtask
	// counts high samples of the pin; a sync delay is skipped first
	task automatic pin_ones(input int n);
		repeat (8) @(posedge ref_clk);
		ones = 0;
		repeat (n) begin
			@(posedge ref_clk);
			ones += int'(cal_pin === 1'h1);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'h1;
		// locked writes are dropped
		rd_check(OFS_CFG, 32'h0);
		apb(1'h1, OFS_ALARM_HOUR, 32'h12);
		rd_check(OFS_ALARM_HOUR, 32'h0);
		apb(1'h1, OFS_VAL_LOW, 32'h33);
		rd_check(OFS_VAL_LOW, 32'h0);
		apb(1'h1, OFS_CFG, 32'h80);
		rd_check(OFS_CFG, 32'h0);
		// an access between the keys spoils the sequence
		apb(1'h1, OFS_UNLOCK_SEQ, 32'h55);
		rd_check(OFS_UNLOCK_SEQ, 32'h0);
		apb(1'h1, OFS_UNLOCK_SEQ, 32'hAA);
		apb(1'h1, OFS_CFG, 32'h20);
		rd_check(OFS_CFG, 32'h0);
		apb(1'h1, OFS_UNLOCK_SEQ, 32'h55);
		apb(1'h1, OFS_UNLOCK_SEQ, 32'hAA);
		apb(1'h1, OFS_CFG, 32'h20);
		rd_check(OFS_CFG, 32'h20);
		// all-ones first, then random words, cut to the digit fields
		for (int i = 0; i < 12; i++) begin
			seed = xorshift(seed);
			d = (i < 3) ? 32'hFFFFFFFF : seed;
			a = OFS_ALARM_HOUR + 8'(4 * (i % 3));
			apb(1'h1, a, d);
			rd_check(a, d & alarm_mask(a));
		end
		// fill every time field through the windows, then read back
		apb(1'h1, OFS_CFG, 32'h23);
		foreach (win_addr[i]) apb(1'h1, win_addr[i], {24'h0, win_data[i]});
		apb(1'h1, OFS_CFG, 32'h23);
		foreach (win_addr[i]) rd_check(win_addr[i], {24'h0, win_data[i]});
		rd_check(OFS_VAL_HIGH, 32'h59);
		// a transfer while the clock enable is low must leave no trace
		apb(1'h1, OFS_ALARM_MINUTE, 32'h11);
		clk_en <= 1'h0;
		apb(1'h1, OFS_ALARM_MINUTE, 32'h22);
		clk_en <= 1'h1;
		rd_check(OFS_ALARM_MINUTE, 32'h11);
		apb(1'h1, OFS_HALF_SEC, 32'h1);
		rd_check(OFS_HALF_SEC, 32'h0);
		apb(1'h0, 8'h24, 32'h0);
		check({31'h0, e}, 32'h1);
		// internal clock onto the pin, then pin off
		apb(1'h1, OFS_PAD_CFG, 32'h4);
		pin_ones(60);
		check(32'(ones > 10 && ones < 50), 32'h1);
		apb(1'h1, OFS_PAD_CFG, 32'h0);
		pin_ones(40);
		check(32'(ones), 32'h0);
		// once the unlock flag is cleared, the run bit can no longer be changed
		apb(1'h1, OFS_CFG, 32'hA0);
		rd_check(OFS_CFG, 32'hA0);
		apb(1'h1, OFS_CFG, 32'h80);
		apb(1'h1, OFS_CFG, 32'h00);
		rd_check(OFS_CFG, 32'h80);
		final_report();
	end

	// about 70 transfers of three cycles plus pin sampling fit well inside
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		final_report();
	end
endmodule
